// >>> rtl/byte_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two and one clock for both sides.
 */
`timescale 1ns/10ps
module byte_fifo import i2c_port_pkg::*; #(
   parameter int WIDTH = FIFO_WIDTH,
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input  wire logic   mclk_i,
   input  wire logic   nrst_i,
   // queue ports
   byte_stream_if.store q
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   wire              push_w = q.in_valid & q.in_ready;
   wire              pop_w  = q.out_valid & q.out_ready;

   assign q.in_ready  = cnt_q != (AW+1)'(DEPTH);
   assign q.out_valid = cnt_q != '0;
   assign q.out_data  = mem[rp_q];

   always_ff @(posedge mclk_i) begin
      if (push_w) begin
         mem[wp_q] <= q.in_data;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         wp_q  <= push_w ? wp_q + 1'b1 : wp_q;
         rp_q  <= pop_w ? rp_q + 1'b1 : rp_q;
         cnt_q <= cnt_q + (AW+1)'(push_w) - (AW+1)'(pop_w);
      end
   end
endmodule

// >>> rtl/byte_stream_if.sv
/*
 * Valid/ready carrier between the register port and its transmit queue.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface byte_stream_if #(parameter int W = 8);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;

   modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
   modport user  (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// >>> rtl/i2c_port_pkg.sv
/*
 * Constants for the byte-level two-wire bus master: register offsets, control field positions, reset values,
 * bus timing and the transmit queue shape.
 * Assumes a 100 MHz core clock and an 8-bit memory-mapped register port with 16-bit addresses.
 */
package i2c_port_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [15:0] ADDR_CONTROL_STATUS = 16'hFFC0;
   localparam logic [15:0] ADDR_TRANSMIT_BYTE  = 16'hFFC1;
   localparam logic [15:0] ADDR_RECEIVE_BYTE   = 16'hFFC2;
   localparam logic [15:0] ADDR_TARGET_SELECT  = 16'hFFC3;

   localparam logic [7:0]  RESET_BYTE          = 8'h00;

   // ---------------------------------------------------------------
   // control and status field positions
   // ---------------------------------------------------------------
   localparam int BIT_RX_FULL    = 7;
   localparam int BIT_RX_IE      = 6;
   localparam int BIT_ERROR      = 5;
   localparam int BIT_SPEED      = 4;
   localparam int BIT_TX_EMPTY   = 3;
   localparam int BIT_TX_IE      = 2;
   localparam int BIT_STOP_READ  = 1;
   localparam int BIT_STOP_WRITE = 0;
   localparam int BIT_DIRECTION  = 0;

   // ---------------------------------------------------------------
   // timing: each bus bit is four quarter periods
   // ---------------------------------------------------------------
   localparam int CLK_HZ       = 100_000_000;
   localparam int SCL_STD_HZ   = 100_000;
   localparam int SCL_FAST_HZ  = 400_000;
   localparam logic [15:0] QUARTER_STD  = 16'(CLK_HZ / (4 * SCL_STD_HZ));
   localparam logic [15:0] QUARTER_FAST = 16'(CLK_HZ / (4 * SCL_FAST_HZ));

   // ---------------------------------------------------------------
   // transmit queue
   // ---------------------------------------------------------------
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 8;

   typedef enum logic [3:0] {
      ST_IDLE, ST_START, ST_WBIT, ST_WACK, ST_WAIT_TX, ST_RBIT, ST_RACK, ST_WAIT_RX, ST_STOP
   } bus_state_type;

endpackage

// >>> rtl/i2c_register_port.sv
/*
 * Byte-level two-wire bus master behind four memory-mapped registers, with an 8-deep transmit queue.
 * Assumes a single-cycle MCU register strobe, open-drain pads resolved outside, and an external vector
 * register that pulses vec_write_i on any write to it.
 */
`timescale 1ns/10ps
module i2c_register_port import i2c_port_pkg::*; (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        nrst_i,
   // mcu register port
   input  wire logic [15:0] reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_write_i,
   input  wire logic        reg_read_i,
   output logic      [7:0]  reg_rdata_o,
   output logic             tx_ready_o,
   // interrupt vector side
   input  wire logic        vec_write_i,
   input  wire logic        other_irq_i,
   output logic             block_irq_o,
   output logic             processor_interrupt_line_o,
   // two-wire bus pads
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe_o,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o
);

   // ---------------------------------------------------------------
   // registers and decode
   // ---------------------------------------------------------------
   logic [7:0]    target_q;
   logic [7:0]    rx_byte_q;
   logic [7:0]    rdata_q;
   logic          rx_full_q, rx_ie_q, err_q, speed_q, tx_empty_q, tx_ie_q, stop_rd_q, stop_wr_q;
   logic          rx_irq_q, tx_irq_q;
   logic          rx_ev, tx_ev, nack_ev, pop;

   wire sel_ctl = reg_addr_i == ADDR_CONTROL_STATUS;
   wire sel_tx  = reg_addr_i == ADDR_TRANSMIT_BYTE;
   wire sel_rx  = reg_addr_i == ADDR_RECEIVE_BYTE;
   wire sel_tgt = reg_addr_i == ADDR_TARGET_SELECT;
   wire wr_ctl  = reg_write_i & sel_ctl;
   wire wr_tx   = reg_write_i & sel_tx;
   wire rd_rx   = reg_read_i & sel_rx;
   wire wr_tgt  = reg_write_i & sel_tgt;

   wire [7:0] ctl_view = {rx_full_q, rx_ie_q, err_q, speed_q, tx_empty_q, tx_ie_q, stop_rd_q, stop_wr_q};
   wire [7:0] rd_mux;
   // transmit byte is write-only and unmapped addresses read zero
   assign rd_mux = sel_ctl ? ctl_view :
                   sel_rx  ? rx_byte_q :
                   sel_tgt ? target_q : RESET_BYTE;

   // ---------------------------------------------------------------
   // transmit queue
   // ---------------------------------------------------------------
   byte_stream_if #(.W(FIFO_WIDTH)) txq ();

   byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_txq (
      .mclk_i (mclk_i),
      .nrst_i (nrst_i),
      .q      (txq.store)
   );

   // a write while the queue is full is dropped; software watches tx_ready_o
   assign txq.in_valid = wr_tx;
   assign txq.in_data  = reg_wdata_i;
   assign txq.out_ready = pop;
   assign tx_ready_o   = txq.in_ready;

   // ---------------------------------------------------------------
   // pad input synchronisers
   // ---------------------------------------------------------------
   logic [2:0] sda_s_q, scl_s_q;
   logic       sda_f_q, scl_f_q;

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         sda_s_q <= 3'h7;
         scl_s_q <= 3'h7;
         sda_f_q <= 1'b1;
         scl_f_q <= 1'b1;
      end else begin
         sda_s_q <= {sda_s_q[1:0], sda_i};
         scl_s_q <= {scl_s_q[1:0], scl_i};
         sda_f_q <= (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
         scl_f_q <= (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
      end
   end

   // ---------------------------------------------------------------
   // quarter-bit tick
   // ---------------------------------------------------------------
   logic [15:0] div_q;
   logic        tick_q;
   wire  [15:0] quarter = speed_q ? QUARTER_FAST : QUARTER_STD;

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         div_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         div_q  <= (div_q == 16'h0000) ? quarter - 16'h0001 : div_q - 16'h0001;
         tick_q <= div_q == 16'h0000;
      end
   end

   // ---------------------------------------------------------------
   // bus sequencer
   // ---------------------------------------------------------------
   bus_state_type st_q, st_d;
   logic [1:0]    ph_q, ph_d;
   logic [2:0]    bit_q, bit_d;
   logic [7:0]    sh_q, sh_d;
   logic          scl_q, scl_d, sda_q, sda_d;
   logic          rdp_q, rdp_d, dat_q, dat_d, nack_q, nack_d;

   // a target holding the clock low stretches the high phase
   wire step = tick_q & ~(ph_q == 2'd2 & ~scl_f_q);

   always_comb begin
      st_d = st_q;
      ph_d = ph_q;
      bit_d = bit_q;
      sh_d = sh_q;
      scl_d = scl_q;
      sda_d = sda_q;
      rdp_d = rdp_q;
      dat_d = dat_q;
      nack_d = nack_q;
      pop = 1'b0;
      rx_ev = 1'b0;
      tx_ev = 1'b0;
      nack_ev = 1'b0;
      if (st_q == ST_IDLE) begin
         scl_d = 1'b1;
         sda_d = 1'b1;
         ph_d = 2'd0;
         if (txq.out_valid) begin
            st_d = ST_START;
            rdp_d = 1'b0;
         end
      end else if (st_q == ST_WAIT_TX) begin
         ph_d = 2'd0;
         if (txq.out_valid) begin
            pop = 1'b1;
            sh_d = txq.out_data;
            dat_d = 1'b1;
            bit_d = 3'd0;
            st_d = ST_WBIT;
         end else if (stop_wr_q) begin
            st_d = ST_STOP;
         end else if (target_q[BIT_DIRECTION] && dat_q) begin
            rdp_d = 1'b1;
            st_d = ST_START;
         end
      end else if (st_q == ST_WAIT_RX) begin
         ph_d = 2'd0;
         if (!rx_full_q) begin
            bit_d = 3'd0;
            st_d = ST_RBIT;
         end
      end else if (step) begin
         ph_d = ph_q + 2'd1;
         case (st_q)
            ST_START: begin
               case (ph_q)
                  2'd0: sda_d = 1'b1;
                  2'd1: scl_d = 1'b1;
                  2'd2: sda_d = 1'b0;
                  default: begin
                     scl_d = 1'b0;
                     sh_d = {target_q[7:1], rdp_q};
                     bit_d = 3'd0;
                     dat_d = 1'b0;
                     st_d = ST_WBIT;
                  end
               endcase
            end
            ST_WBIT: begin
               case (ph_q)
                  2'd0: sda_d = sh_q[7];
                  2'd1: scl_d = 1'b1;
                  2'd2: sda_d = sda_q;
                  default: begin
                     scl_d = 1'b0;
                     sh_d = {sh_q[6:0], 1'b0};
                     bit_d = bit_q + 3'd1;
                     if (bit_q == 3'd7) begin
                        st_d = ST_WACK;
                     end
                  end
               endcase
            end
            ST_WACK: begin
               case (ph_q)
                  2'd0: sda_d = 1'b1;
                  2'd1: scl_d = 1'b1;
                  2'd2: nack_d = sda_f_q;
                  default: begin
                     scl_d = 1'b0;
                     if (nack_q) begin
                        nack_ev = 1'b1;
                        st_d = ST_STOP;
                     end else if (rdp_q) begin
                        bit_d = 3'd0;
                        st_d = ST_RBIT;
                     end else begin
                        tx_ev = dat_q & ~txq.out_valid;
                        st_d = ST_WAIT_TX;
                     end
                  end
               endcase
            end
            ST_RBIT: begin
               case (ph_q)
                  2'd0: sda_d = 1'b1;
                  2'd1: scl_d = 1'b1;
                  2'd2: sh_d = {sh_q[6:0], sda_f_q};
                  default: begin
                     scl_d = 1'b0;
                     bit_d = bit_q + 3'd1;
                     if (bit_q == 3'd7) begin
                        rx_ev = 1'b1;
                        st_d = ST_RACK;
                     end
                  end
               endcase
            end
            ST_RACK: begin
               case (ph_q)
                  2'd0: sda_d = stop_rd_q;
                  2'd1: scl_d = 1'b1;
                  2'd2: sda_d = sda_q;
                  default: begin
                     scl_d = 1'b0;
                     st_d = stop_rd_q ? ST_STOP : ST_WAIT_RX;
                  end
               endcase
            end
            default: begin
               case (ph_q)
                  2'd0: sda_d = 1'b0;
                  2'd1: scl_d = 1'b1;
                  2'd2: sda_d = 1'b1;
                  default: st_d = ST_IDLE;
               endcase
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         st_q <= ST_IDLE;
         ph_q <= 2'd0;
         bit_q <= 3'd0;
         sh_q <= RESET_BYTE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         rdp_q <= 1'b0;
         dat_q <= 1'b0;
         nack_q <= 1'b0;
      end else begin
         st_q <= st_d;
         ph_q <= ph_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         scl_q <= scl_d;
         sda_q <= sda_d;
         rdp_q <= rdp_d;
         dat_q <= dat_d;
         nack_q <= nack_d;
      end
   end

   // open drain: only ever pull low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = ~scl_q;
   assign sda_oe_o = ~sda_q;

   // ---------------------------------------------------------------
   // register file; hardware sets win over same-cycle clears
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         target_q <= RESET_BYTE;
         rx_byte_q <= RESET_BYTE;
         rdata_q <= RESET_BYTE;
         {rx_full_q, rx_ie_q, err_q, speed_q, tx_empty_q, tx_ie_q, stop_rd_q, stop_wr_q} <= RESET_BYTE;
      end else begin
         rdata_q <= reg_read_i ? rd_mux : rdata_q;
         target_q <= wr_tgt ? reg_wdata_i : target_q;
         rx_byte_q <= rx_ev ? sh_q : rx_byte_q;
         rx_full_q <= rx_ev | (rx_full_q & ~rd_rx);
         tx_empty_q <= tx_ev | (tx_empty_q & ~wr_tx);
         err_q <= nack_ev | (err_q & ~(wr_ctl & ~reg_wdata_i[BIT_ERROR]));
         if (wr_ctl) begin
            rx_ie_q <= reg_wdata_i[BIT_RX_IE];
            speed_q <= reg_wdata_i[BIT_SPEED];
            tx_ie_q <= reg_wdata_i[BIT_TX_IE];
            stop_rd_q <= reg_wdata_i[BIT_STOP_READ];
            stop_wr_q <= reg_wdata_i[BIT_STOP_WRITE];
         end
      end
   end

   // ---------------------------------------------------------------
   // interrupt requests
   // ---------------------------------------------------------------
   // pending bits are separate from the flags so acknowledging leaves the flags alone
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         rx_irq_q <= 1'b0;
         tx_irq_q <= 1'b0;
      end else begin
         rx_irq_q <= (rx_ev & rx_ie_q) | (rx_irq_q & ~vec_write_i);
         tx_irq_q <= (tx_ev & tx_ie_q) | (tx_irq_q & ~vec_write_i);
      end
   end

   assign reg_rdata_o = rdata_q;
   assign block_irq_o = rx_irq_q | tx_irq_q;
   assign processor_interrupt_line_o = block_irq_o | other_irq_i;

endmodule

// >>> sim/i2c_master_register_port_tb.sv
/*
 * Bench for the register port: mcu register tasks, pulled-up bus with a target model, queue of expected bytes.
 * Assumes the checker file is compiled before this one.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module i2c_master_register_port_tb import i2c_port_pkg::*; ;
   logic        mclk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic [15:0] reg_addr_i = 16'h0000;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic [7:0]  reg_rdata_o;
   logic [7:0]  rd_byte = 8'h00;
   logic        reg_write_i = 1'b0, reg_read_i = 1'b0, vec_write_i = 1'b0, other_irq_i = 1'b0;
   logic        nack = 1'b0, stretch = 1'b0;
   logic        tx_ready_o, block_irq_o, pint, scl_o, scl_oe_o, sda_o, sda_oe_o, sda_pull, scl_pull, act;
   wire         scl = !(scl_oe_o || scl_pull);
   wire         sda = !(sda_oe_o || sda_pull);
   int          err_count = 0;
   int          n_tests = 0;
   logic [31:0] seed = 32'h7FCE;
   logic [7:0]  exp_q[$];
   always #5 mclk_i = !mclk_i;
   i2c_register_port dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .tx_ready_o(tx_ready_o),
      .vec_write_i(vec_write_i), .other_irq_i(other_irq_i), .block_irq_o(block_irq_o),
      .processor_interrupt_line_o(pint), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o));
   i2c_target_model #(.OWN_ADDR(7'h2A)) tgt_u (.scl_i(scl), .sda_i(sda), .nack_i(nack), .stretch_i(stretch),
      .rd_byte_i(rd_byte), .sda_pull_o(sda_pull), .scl_pull_o(scl_pull), .active_o(act));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_write_i = 1'b1;
      @(negedge mclk_i);
      reg_write_i = 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [15:0] a, input logic [7:0] e);
      @(negedge mclk_i);
      reg_addr_i = a;
      reg_read_i = 1'b1;
      @(negedge mclk_i);
      reg_read_i = 1'b0;
      `CHK(nm, e, reg_rdata_o)
   endtask
   task automatic vec();
      @(negedge mclk_i);
      vec_write_i = 1'b1;
      @(negedge mclk_i);
      vec_write_i = 1'b0;
   endtask
   // waits for a start and then a stop seen by the target
   task automatic wait_bus();
      int n = 0;
      while (!act && n < 60000) begin
         @(negedge mclk_i);
         n++;
      end
      while (act && n < 60000) begin
         @(negedge mclk_i);
         n++;
      end
      if (n >= 60000) begin
         err_count++;
         print_verdict();
      end
   endtask
   task automatic cmp_bytes();
      `CHK("count", exp_q.size(), tgt_u.got_q.size())
      foreach (exp_q[i]) `CHK("byte", exp_q[i], tgt_u.got_q[i])
      tgt_u.got_q.delete();
   endtask
   // two rising edges of the bus clock, polled at the falling core edge so the wait stays bounded
   task automatic period(input realtime lo);
      realtime t0;
      int      n;
      int      r;
      logic    p;
      t0 = 0.0;
      n = 0;
      r = 0;
      p = scl;
      while (r < 2 && n < 30000) begin
         @(negedge mclk_i);
         n++;
         if (scl === 1'b1 && p === 1'b0) begin
            r++;
            if (r == 1) begin
               t0 = $realtime;
            end
         end
         p = scl;
      end
      if (r < 2) begin
         err_count++;
         print_verdict();
      end
      `CHK("scl period", 1'b1, ($realtime - t0) >= lo && ($realtime - t0) <= lo * 1.05)
   endtask
   initial begin
      logic [7:0] v;
      int         k;
      repeat (6) @(negedge mclk_i);
      nrst_i = 1'b1;
      rchk("ctrl", ADDR_CONTROL_STATUS, 8'h00);
      rchk("rxb", ADDR_RECEIVE_BYTE, 8'h00);
      rchk("tgt", ADDR_TARGET_SELECT, 8'h00);
      rchk("txb", ADDR_TRANSMIT_BYTE, 8'h00);
      rchk("unmapped", 16'hFFC4, 8'h00);
      // status bits and the error bit cannot be set by software
      wr(ADDR_CONTROL_STATUS, 8'hFF);
      rchk("ctrl", ADDR_CONTROL_STATUS, 8'h57);
      v = rnd();
      wr(ADDR_TARGET_SELECT, v);
      rchk("tgt", ADDR_TARGET_SELECT, v);
      // fill the queue against a slow target, write-stop at the end
      wr(ADDR_TARGET_SELECT, 8'h54);
      wr(ADDR_CONTROL_STATUS, 8'h15);
      v = rnd();
      other_irq_i = v[0];
      stretch = 1'b1;
      exp_q = {8'h54};
      k = 0;
      while (tx_ready_o === 1'b1 && k < 12) begin
         v = rnd();
         wr(ADDR_TRANSMIT_BYTE, v);
         exp_q.push_back(v);
         k++;
      end
      `CHK("refuse", 1'b1, k == FIFO_DEPTH && tx_ready_o === 1'b0)
      wr(ADDR_TRANSMIT_BYTE, 8'hEE);
      rchk("ctrl", ADDR_CONTROL_STATUS, 8'h15);
      wait_bus();
      stretch = 1'b0;
      cmp_bytes();
      rchk("ctrl", ADDR_CONTROL_STATUS, 8'h1D);
      `CHK("irq", 1'b1, block_irq_o)
      `CHK("line", 1'b1, pint)
      vec();
      `CHK("irq", 1'b0, block_irq_o)
      `CHK("line", other_irq_i, pint)
      rchk("ctrl", ADDR_CONTROL_STATUS, 8'h1D);
      // register address then repeated start read, stop after one byte at 100 kHz
      wr(ADDR_TARGET_SELECT, 8'h55);
      wr(ADDR_CONTROL_STATUS, 8'h42);
      rd_byte = rnd();
      wr(ADDR_TRANSMIT_BYTE, 8'h3C);
      rchk("ctrl", ADDR_CONTROL_STATUS, 8'h42);
      period(10000.0);
      wait_bus();
      exp_q = {8'h54, 8'h3C, 8'h55};
      cmp_bytes();
      rchk("ctrl", ADDR_CONTROL_STATUS, 8'hCA);
      `CHK("irq", 1'b1, block_irq_o)
      vec();
      rchk("ctrl", ADDR_CONTROL_STATUS, 8'hCA);
      rchk("rxb", ADDR_RECEIVE_BYTE, rd_byte);
      rchk("ctrl", ADDR_CONTROL_STATUS, 8'h4A);
      wr(ADDR_CONTROL_STATUS, 8'h00);
      // no response: error stays until software clears it
      nack = 1'b1;
      wr(ADDR_TARGET_SELECT, 8'h54);
      wr(ADDR_CONTROL_STATUS, 8'h11);
      wr(ADDR_TRANSMIT_BYTE, 8'hA5);
      period(2480.0);
      wait_bus();
      vec();
      repeat (2000) @(negedge mclk_i);
      rchk("ctrl err", ADDR_CONTROL_STATUS, 8'h31);
      wr(ADDR_CONTROL_STATUS, 8'h00);
      rchk("ctrl", ADDR_CONTROL_STATUS, 8'h00);
      print_verdict();
   end
endmodule
bind i2c_register_port i2c_register_port_checker chk_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
   .tx_ready_o(tx_ready_o), .vec_write_i(vec_write_i), .other_irq_i(other_irq_i), .block_irq_o(block_irq_o),
   .processor_interrupt_line_o(processor_interrupt_line_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

// >>> sim/i2c_register_port_checker.sv
/*
 * Concurrent checks on the register port top.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/10ps
module i2c_register_port_checker import i2c_port_pkg::*; (
   // clock and reset
   input wire logic        mclk_i,
   input wire logic        nrst_i,
   // register port
   input wire logic [15:0] reg_addr_i,
   input wire logic [7:0]  reg_wdata_i,
   input wire logic        reg_write_i,
   input wire logic        reg_read_i,
   input wire logic [7:0]  reg_rdata_o,
   input wire logic        tx_ready_o,
   // interrupts
   input wire logic        vec_write_i,
   input wire logic        other_irq_i,
   input wire logic        block_irq_o,
   input wire logic        processor_interrupt_line_o,
   // pads
   input wire logic        scl_i,
   input wire logic        scl_o,
   input wire logic        scl_oe_o,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   // shadows of the software-owned bits only
   logic [7:0] ctl_q;
   logic [7:0] tgt_q;
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         ctl_q <= 8'h00;
         tgt_q <= 8'h00;
      end else if (reg_write_i && reg_addr_i == ADDR_CONTROL_STATUS) begin
         ctl_q <= reg_wdata_i & 8'h57;
      end else if (reg_write_i && reg_addr_i == ADDR_TARGET_SELECT) begin
         tgt_q <= reg_wdata_i;
      end
   end
   sequence rd_s(a);
      reg_read_i && reg_addr_i == a;
   endsequence
   irq_or_a: assert property (processor_interrupt_line_o == (block_irq_o | other_irq_i))
      else $error("interrupt line differs from or of sources");
   vec_clear_a: assert property (vec_write_i && !scl_oe_o && !sda_oe_o |=> !block_irq_o)
      else $error("vector write left interrupt pending");
   tgt_back_a: assert property (rd_s(ADDR_TARGET_SELECT) |=> reg_rdata_o == $past(tgt_q))
      else $error("target select read back wrong");
   ctl_back_a: assert property (rd_s(ADDR_CONTROL_STATUS) |=> (reg_rdata_o & 8'h57) == $past(ctl_q))
      else $error("control bits read back wrong");
   wo_read_a: assert property (reg_read_i && (reg_addr_i == ADDR_TRANSMIT_BYTE || reg_addr_i[15:2] != 14'h3FF0)
      |=> reg_rdata_o == 8'h00)
      else $error("write-only or unmapped read not zero");
   rdata_hold_a: assert property (!reg_read_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   reset_val_a: assert property ($rose(nrst_i) |-> reg_rdata_o == 8'h00 && !block_irq_o && !scl_oe_o && !sda_oe_o)
      else $error("outputs not at reset values");
   irq_en_a: assert property ($rose(block_irq_o) |-> ctl_q[BIT_RX_IE] || ctl_q[BIT_TX_IE])
      else $error("interrupt raised while disabled");
   scl_low_a: assert property ($rose(scl_oe_o) |=> scl_oe_o [*8])
      else $error("clock low phase too short");
   open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
      else $error("pad drives high");
endmodule

// >>> sim/i2c_target_model.sv
/*
 * Behavioural two-wire target: acks its own address, captures written bytes, returns one byte on reads.
 * Assumes the bench resolves both wires with pull-ups from every party's pull-down.
 */
`timescale 1ns/10ps
module i2c_target_model #(
   parameter logic [6:0] OWN_ADDR = 7'h2A
) (
   // bus wires
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   // behaviour control
   input  wire logic       nack_i,
   input  wire logic       stretch_i,
   input  wire logic [7:0] rd_byte_i,
   // pull-downs and status
   output logic            sda_pull_o,
   output logic            scl_pull_o,
   output logic            active_o
);
   logic [7:0] got_q[$];
   logic [7:0] sh;
   logic       rd;
   logic       adr;
   logic       mnack;
   int         cnt;
   initial begin
      sda_pull_o = 1'b0;
      scl_pull_o = 1'b0;
      active_o = 1'b0;
      cnt = 0;
   end
   always @(negedge sda_i) begin
      if (scl_i === 1'b1) begin
         active_o = 1'b1;
         adr = 1'b1;
         rd = 1'b0;
         cnt = 0;
      end
   end
   always @(posedge sda_i) begin
      if (scl_i === 1'b1) begin
         active_o = 1'b0;
      end
   end
   // msb first, ninth clock is the acknowledge
   always @(posedge scl_i) begin
      if (active_o) begin
         if (cnt < 8) begin
            sh = {sh[6:0], sda_i};
         end else begin
            mnack = sda_i;
         end
         cnt = cnt + 1;
      end
   end
   always @(negedge scl_i) begin
      if (active_o && cnt == 9) begin
         cnt = 0;
         rd = (adr ? sh[0] : rd) && !mnack;
         adr = 1'b0;
      end
      if (active_o && cnt == 8 && !rd) begin
         got_q.push_back(sh);
         sda_pull_o = !nack_i && (!adr || sh[7:1] == OWN_ADDR);
      end else begin
         sda_pull_o = active_o && rd && cnt < 8 && !rd_byte_i[7 - cnt];
      end
   end
   // a slow target holds the clock low after every falling edge; long enough to reach into the
   // master's high phase at the fast rate, so the master really has to wait for the line
   always @(negedge scl_i) begin
      if (stretch_i && active_o) begin
         scl_pull_o = 1'b1;
         #2000;
         scl_pull_o = 1'b0;
      end
   end
endmodule
